/* File: bench/idc_props.sv */
// Purpose: wire checks between controller and target
// Assumes: one CLK domain, synchronous RESET
// Notes:   sees only the open-drain link signals
`default_nettype none

module idc_props (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_t_oe
);
  // ----------
  // frame tracking
  // ----------
  logic scl_q;
  logic sda_q;
  logic [5:0] rises;
  logic [5:0] next_rises;
  logic [7:0] head;
  logic [7:0] next_head;
  logic hit;
  logic rd;

  // clock rises since start; saturates so an overrun cannot wrap to a legal count
  always_comb begin
    next_rises = rises;
    next_head = head;
    if (scl && scl_q && sda_q && !sda) begin
      next_rises = 6'h00;
    end else if (scl && !scl_q && rises != 6'h3F) begin
      next_rises = rises + 6'h01;
      if (rises < 6'h08) begin
        next_head = {head[6:0], sda};
      end
    end
  end

  // register the view of the wires
  always_ff @(posedge CLK) begin
    if (RESET) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      rises <= 6'h00;
      head <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      rises <= next_rises;
      head <= next_head;
    end
  end

  // address group and direction of the current frame
  assign hit = (head[7:3] == 5'h03);
  assign rd = head[0];

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  // ----------
  // assertions
  // ----------
  tgt_hold_a: assert property ($rose(scl) |-> $stable(sda_t_oe) [*8])
    else $error("target data moved while clock high");
  mst_hold_a: assert property ($rose(scl) |-> $stable(sda_m_oe) [*6])
    else $error("controller data moved while clock high");
  addr_ack_a: assert property ($rose(scl) && rises == 6'h08 && hit |-> sda_t_oe)
    else $error("matching address not acknowledged");
  data_ack_a: assert property ($rose(scl) && hit && !rd && (rises == 6'h11 || rises == 6'h1A)
    |-> sda_t_oe)
    else $error("write byte not acknowledged");
  no_match_a: assert property (rises >= 6'h08 && !hit |-> !sda_t_oe)
    else $error("target drives for a foreign address");
  // the clock rise ahead of the stop is counted too
  two_bytes_a: assert property (rises <= 6'h1C)
    else $error("more than two data bytes");
  rd_free_a: assert property ($rose(scl) && hit && rd &&
    rises inside {[6'h09:6'h10], [6'h12:6'h19]} |-> !sda_m_oe)
    else $error("controller drives during read data");
  rd_ack_a: assert property ($rose(scl) && hit && rd && (rises == 6'h11 || rises == 6'h1A)
    |-> sda_m_oe == (rises == 6'h11))
    else $error("read byte ack pattern wrong");
  start_free_a: assert property ($fell(sda) && scl && $past(scl) |-> !sda_t_oe)
    else $error("target holds data at start");
  stop_count_a: assert property ($rose(sda) && scl && $past(scl)
    |-> rises == 6'h0A || rises == 6'h1C)
    else $error("stop at wrong point of frame");
endmodule : idc_props

`default_nettype wire

/* File: bench/testbench.sv */
// Purpose: bench for controller and target joined on one link
// Assumes: 10 MHz clock, zero-wait APB answers
// Notes:   expectations come from the word layout only
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // signals and instances
  // ----------
  logic clk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pd_req_n;
  logic [9:0] code;
  logic power_down;
  logic [15:0] in_word;
  int miscompares;
  int samples_checked;

  idc_bus_if bus ();
  idc_master i_idc_master (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BUS(bus));
  idc_target i_idc_target (.CLK(clk), .RESET(reset), .POWER_DOWN_REQUEST_N(pd_req_n),
    .BUS(bus), .CODE(code), .POWER_DOWN(power_down), .INPUT_WORD(in_word));
  idc_props chk (.CLK(clk), .RESET(reset), .scl(bus.scl), .sda(bus.sda),
    .sda_m_oe(bus.sda_m_oe), .sda_t_oe(bus.sda_t_oe));

  // free-running system clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // ----------
  // shared tasks
  // ----------
  // one counted compare
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check

  // one APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // one link frame, polled to completion; no own limit, the watchdog ends a hang
  task automatic xfer(input logic [6:0] addr, input logic rd, input logic [15:0] word,
                      output logic [31:0] st);
    logic [31:0] r;
    logic e;
    apb(1'h1, idc_pkg::REG_DATA, {16'h0000, word}, r, e);
    apb(1'h1, idc_pkg::REG_CMD, {24'h000000, rd, addr}, r, e);
    do apb(1'h0, idc_pkg::REG_STATUS, 32'h0, st, e);
    while (st[idc_pkg::ST_DONE] !== 1'h1);
  endtask : xfer

  // ----------
  // scenarios
  // ----------
  // idle outputs after reset, and a refused register address
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    check(32'(code), 32'h0, "code after reset");
    check(32'(in_word), 32'h0, "word after reset");
    check(32'(power_down), 32'h0, "power-down after reset");
    apb(1'h0, idc_pkg::REG_STATUS, 32'h0, r, e);
    check(r, 32'h0, "status after reset");
    apb(1'h0, 8'h0C, 32'h0, r, e);
    check(32'(e), 32'h1, "unmapped error flag");
    check(r, 32'h0, "unmapped read data");
    $display("test reset done");
  endtask : t_reset

  // each address of the group, two of the four words with don't-care bits set
  task automatic t_write();
    logic [15:0] words [4] = '{16'h7FFF, 16'h8010, 16'h4AA5, 16'h2000};
    logic [31:0] st;
    for (int i = 0; i < 4; i++) begin
      xfer(7'h0C + 7'(i), 1'h0, words[i], st);
      check(32'(st[idc_pkg::ST_NACK]), 32'h0, "write refused");
      check(32'(in_word), 32'(words[i]), "input word");
      check(32'(code), 32'(words[i][13:4]), "code");
      check(32'(power_down), 32'(words[i][15]), "soft power-down");
    end
    $display("test write done");
  endtask : t_write

  // pin acts before any clock edge; release falls back to the soft bit
  task automatic t_pin();
    @(posedge clk);
    pd_req_n <= 1'h0;
    #10;
    check(32'(power_down), 32'h1, "pin power-down");
    @(posedge clk);
    pd_req_n <= 1'h1;
    repeat (3) @(posedge clk);
    check(32'(power_down), 32'h0, "pin released");
    $display("test pin done");
  endtask : t_pin

  // foreign addresses, one of them a read: no answer, nothing loaded
  task automatic t_nomatch();
    logic [6:0] bad [3] = '{7'h08, 7'h1C, 7'h4F};
    logic [31:0] st;
    foreach (bad[i]) begin
      xfer(bad[i], i == 1, 16'h1234, st);
      check(32'(st[idc_pkg::ST_NACK]), 32'h1, "foreign address answered");
      check(32'(code), 32'h200, "code kept");
      check(32'(in_word), 32'h2000, "word kept");
    end
    $display("test nomatch done");
  endtask : t_nomatch

  // write, read back through another group address, word then cleared
  task automatic t_read();
    logic [31:0] st;
    logic [31:0] r;
    logic e;
    xfer(7'h0E, 1'h0, 16'hB5A3, st);
    xfer(7'h0D, 1'h1, 16'h0000, st);
    check(32'(st[idc_pkg::ST_NACK]), 32'h0, "read refused");
    apb(1'h0, idc_pkg::REG_DATA, 32'h0, r, e);
    check(32'(r[15:0]), 32'hB5A3, "read word");
    check(32'(in_word), 32'h0, "word cleared");
    check(32'(code), 32'h35A, "code kept by read");
    check(32'(power_down), 32'h1, "soft power-down kept by read");
    $display("test read done");
  endtask : t_read

  // counts, verdict and end of run
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // reset, then the scenarios in turn
  initial begin
    miscompares = 0;
    samples_checked = 0;
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pd_req_n = 1'h1;
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    repeat (3) @(posedge clk);
    t_reset();
    t_write();
    t_pin();
    t_nomatch();
    t_read();
    results();
  end

  // a full run needs about 6000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule : testbench

`default_nettype wire

/* File: src/idc_bus_if.sv */
// Purpose: open-drain two-wire link between controller and target
// Assumes: pull-ups on both lines
// Notes:   a line is low while any enabled driver outputs low
`default_nettype none

interface idc_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_t_o;
  logic sda_t_oe;
  logic scl;
  logic sda;

  // wired-and of the drivers, pulled high otherwise
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_t_oe && !sda_t_o));

  modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport target (output sda_t_o, sda_t_oe, input scl, sda);
endinterface : idc_bus_if

`default_nettype wire

/* File: src/idc_master.sv */
// Purpose: two-wire controller driven from APB registers
// Assumes: zero-wait APB slave, one access answered per setup
// Notes:   bus clock made by a quarter-period divider of CLK
//
// The address map and register access over APB were chosen for this implementation.
`default_nettype none

module idc_master (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [idc_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  idc_bus_if.master BUS
);
  logic sda_s;
  logic acc_wr;
  logic go;
  logic busy;
  logic [31:0] rd_mux;
  logic [7:0] cmd, next_cmd;
  logic [15:0] txword, next_txword;
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready;
  logic pslverr, next_pslverr;
  idc_pkg::idc_mstate_t state, next_state;
  logic [3:0] div, next_div;
  logic [1:0] q, next_q;
  logic [3:0] bitn, next_bitn;
  logic [1:0] byten, next_byten;
  logic [7:0] sh, next_sh;
  logic [15:0] rx, next_rx;
  logic ackbit, next_ackbit;
  logic nack, next_nack;
  logic done, next_done;
  logic scl_oe, next_scl_oe;
  logic sda_oe, next_sda_oe;

  idc_sync #(.W(1)) u_sync (
    .CLK(CLK),
    .RESET(RESET),
    .D(BUS.sda),
    .Q(sda_s)
  );

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  assign busy = (state != idc_pkg::M_IDLE);
  assign acc_wr = PSEL && PENABLE && pready && PWRITE;
  // commands while busy are dropped, the status shows why
  assign go = acc_wr && PADDR == idc_pkg::REG_CMD && !busy;

  always_comb begin
    rd_mux = '0;
    case (PADDR)
      idc_pkg::REG_CMD: rd_mux = {24'h000000, cmd};
      idc_pkg::REG_DATA: rd_mux = {16'h0000, rx};
      idc_pkg::REG_STATUS: rd_mux = {29'h00000000, done, nack, busy};
      default: rd_mux = '0;
    endcase
  end

  // answer is prepared in setup, so access completes at once
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    next_cmd = cmd;
    next_txword = txword;
    if (PSEL && !PENABLE) begin
      next_pready = 1'b1;
      next_prdata = rd_mux;
      next_pslverr = !(PADDR == idc_pkg::REG_CMD || PADDR == idc_pkg::REG_DATA ||
                       PADDR == idc_pkg::REG_STATUS);
    end
    if (go) begin
      next_cmd = PWDATA[7:0];
    end
    if (acc_wr && PADDR == idc_pkg::REG_DATA && !busy) begin
      next_txword = PWDATA[15:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      cmd <= '0;
      txword <= '0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      cmd <= next_cmd;
      txword <= next_txword;
    end
  end

  // ----------------------------------------------------------------
  // bit engine, four quarters per bus clock
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_div = (div == idc_pkg::QTR_LAST) ? 4'h0 : div + 4'h1;
    next_q = q;
    next_bitn = bitn;
    next_byten = byten;
    next_sh = sh;
    next_rx = rx;
    next_ackbit = ackbit;
    next_nack = nack;
    next_done = done;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    case (state)
      idc_pkg::M_IDLE: begin
        next_div = '0;
        if (go) begin
          next_sda_oe = 1'b1; // data falls, clock high [R1]
          // address first, direction bit last on the wire [R2]
          next_sh = {PWDATA[idc_pkg::CMD_RD_BIT-1:0], PWDATA[idc_pkg::CMD_RD_BIT]};
          next_rx = '0;
          next_nack = 1'b0;
          next_done = 1'b0;
          next_state = idc_pkg::M_START;
        end
      end
      idc_pkg::M_START: begin
        if (div == idc_pkg::QTR_LAST) begin
          next_scl_oe = 1'b1;
          next_q = '0;
          next_bitn = '0;
          next_byten = '0;
          next_state = idc_pkg::M_BIT;
        end
      end
      idc_pkg::M_BIT: begin
        if (div == idc_pkg::QTR_LAST) begin
          next_q = q + 2'h1;
          case (q)
            2'h0: begin
              // data set only in the clock-low quarter [R5]
              if (bitn == idc_pkg::BYTE_BITS) begin
                next_sda_oe = cmd[idc_pkg::CMD_RD_BIT] && byten == 2'h1;
              end else if (byten == 2'h0 || !cmd[idc_pkg::CMD_RD_BIT]) begin
                next_sda_oe = !sh[7]; // msb first [R9]
              end else begin
                next_sda_oe = 1'b0;
              end
            end
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              if (bitn == idc_pkg::BYTE_BITS) begin
                next_ackbit = sda_s;
              end else begin
                next_sh = {sh[6:0], 1'b0};
                if (byten != 2'h0 && cmd[idc_pkg::CMD_RD_BIT]) begin
                  next_rx = {rx[14:0], sda_s};
                end
              end
            end
            default: begin
              next_scl_oe = 1'b1;
              if (bitn != idc_pkg::BYTE_BITS) begin
                next_bitn = bitn + 4'h1;
              end else begin
                next_bitn = '0;
                if ((byten == 2'h0 || !cmd[idc_pkg::CMD_RD_BIT]) && ackbit) begin
                  next_nack = 1'b1;
                  next_state = idc_pkg::M_STOP;
                end else if (byten == 2'h2) begin
                  next_state = idc_pkg::M_STOP; // two data bytes only [R7]
                end else begin
                  next_byten = byten + 2'h1;
                  next_sh = (byten == 2'h0) ? txword[15:8] : txword[7:0]; // [R9]
                end
              end
            end
          endcase
        end
      end
      idc_pkg::M_STOP: begin
        if (div == idc_pkg::QTR_LAST) begin
          next_q = q + 2'h1;
          case (q)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0; // data rises, clock high [R8]
            default: begin
              next_done = 1'b1;
              next_state = idc_pkg::M_IDLE;
            end
          endcase
        end
      end
      default: next_state = idc_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= idc_pkg::M_IDLE;
      div <= '0;
      q <= '0;
      bitn <= '0;
      byten <= '0;
      sh <= '0;
      rx <= '0;
      ackbit <= 1'b0;
      nack <= 1'b0;
      done <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      q <= next_q;
      bitn <= next_bitn;
      byten <= next_byten;
      sh <= next_sh;
      rx <= next_rx;
      ackbit <= next_ackbit;
      nack <= next_nack;
      done <= next_done;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
    end
  end

  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;
  assign BUS.scl_o = 1'b0;
  assign BUS.scl_oe = scl_oe;
  assign BUS.sda_m_o = 1'b0;
  assign BUS.sda_m_oe = sda_oe;
endmodule : idc_master

`default_nettype wire

/* File: src/idc_pkg.sv */
// Purpose: shared constants and types of the serial converter-code link
// Assumes: one 10 MHz system clock on both ends
// Notes:   both ends and the bench refer to these names only
`default_nettype none

package idc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 2500;
  // a quarter of the bus clock is a least time, so round up
  localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] QTR_LAST = 4'(QTR_CYC - 1);

  // ----------------------------------------------------------------
  // target address and word layout
  // ----------------------------------------------------------------
  localparam logic [4:0] TARGET_ADDR_HI = 5'h03;
  localparam int PD_BIT = 15;
  localparam int CODE_MSB = 13;
  localparam int CODE_LSB = 4;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] BYTES_ADDR = 2'h1;
  localparam logic [1:0] BYTES_HI = 2'h2;
  localparam logic [1:0] BYTES_ALL = 2'h3;

  // ----------------------------------------------------------------
  // controller registers on the peripheral bus
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CMD_RD_BIT = 7;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_DONE = 2;

  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ACK, T_WR, T_RD, T_RACK, T_IGNORE} idc_tstate_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} idc_mstate_t;
endpackage : idc_pkg

`default_nettype wire

/* File: src/idc_sync.sv */
// Purpose: two-flop synchroniser for line levels
// Assumes: inputs asynchronous to CLK
// Notes:   the first stage is read only by the second
`default_nettype none

module idc_sync #(
  parameter int W = 1
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // two stages, idle lines reset high
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      meta <= '1;
      Q <= '1;
    end else begin
      meta <= D;
      Q <= meta;
    end
  end
endmodule : idc_sync

`default_nettype wire

/* File: src/idc_target.sv */
// Purpose: two-wire target that loads a 16-bit word into a converter code
// Assumes: bus lines sampled by CLK, bus clock well below CLK / 8
// Notes:   power-down pin acts without the clock
`default_nettype none

// Overview of operation
// (R1) start: data falls while clock high
// (R2) first byte: address then direction bit
// (R3) match upper five address bits only
// (R4) ack: hold data low through ninth clock
// (R5) data changes only while clock low
// (R6) acknowledge every received byte
// (R7) exactly two data bytes per transfer
// (R8) stop: data rises while clock high
// (R9) high byte first, msb first, shifted
// (R10) after both bytes, load code register
// (R11) word bit 15 is soft power-down
// (R12) word bits 13..4 are the code
// (R13) bit 14 and bits 3..0 ignored
// (R14) reads return word, high byte first
// (R15) word cleared after a read completes
// (R16) power-down pin forces power-down asynchronously
// (R17) no match: stay released until start
// (R18) short write leaves code unchanged
module idc_target (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic POWER_DOWN_REQUEST_N,
  idc_bus_if.target BUS,
  output logic [9:0] CODE,
  output logic POWER_DOWN,
  output logic [15:0] INPUT_WORD
);
  logic [1:0] line_s;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic start_ev;
  logic stop_ev;
  logic rise;
  logic fall;
  idc_pkg::idc_tstate_t state, next_state;
  logic [7:0] shreg, next_shreg;
  logic [7:0] tx, next_tx;
  logic [3:0] bitcnt, next_bitcnt;
  logic [1:0] bytes, next_bytes;
  logic rw, next_rw;
  logic sda_oe, next_sda_oe;
  logic [15:0] word, next_word;
  logic [9:0] code, next_code;
  logic soft_pd, next_soft_pd;

  // ----------------------------------------------------------------
  // line sampling and condition detection
  // ----------------------------------------------------------------
  idc_sync #(.W(2)) u_sync (
    .CLK(CLK),
    .RESET(RESET),
    .D({BUS.scl, BUS.sda}),
    .Q(line_s)
  );
  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  // delayed copies for edge finding
  always_ff @(posedge CLK) begin
    if (RESET) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign start_ev = scl_s && scl_d && sda_d && !sda_s; // [R1]
  assign stop_ev = scl_s && scl_d && !sda_d && sda_s; // [R8]
  assign rise = scl_s && !scl_d;
  assign fall = !scl_s && scl_d;

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  // next values; every drive change follows a seen clock fall
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_tx = tx;
    next_bitcnt = bitcnt;
    next_bytes = bytes;
    next_rw = rw;
    next_sda_oe = sda_oe;
    next_word = word;
    next_code = code;
    next_soft_pd = soft_pd;
    if (start_ev) begin
      // a repeated start drops a half-done write [R18]
      next_state = idc_pkg::T_ADDR;
      next_bitcnt = '0;
      next_bytes = '0;
      next_sda_oe = 1'b0;
    end else if (stop_ev) begin
      next_state = idc_pkg::T_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        idc_pkg::T_ADDR, idc_pkg::T_WR: begin
          if (rise && bitcnt != idc_pkg::BYTE_BITS) begin
            next_shreg = {shreg[6:0], sda_s}; // [R9]
            next_bitcnt = bitcnt + 4'h1;
          end else if (fall && bitcnt == idc_pkg::BYTE_BITS) begin
            next_bitcnt = '0;
            next_bytes = bytes + 2'h1;
            if (state == idc_pkg::T_ADDR) begin
              if (shreg[7:3] == idc_pkg::TARGET_ADDR_HI) begin // [R3] [R2]
                next_rw = shreg[0];
                next_sda_oe = 1'b1; // [R4] [R6]
                next_state = idc_pkg::T_ACK;
              end else begin
                next_state = idc_pkg::T_IGNORE; // [R17]
              end
            end else begin
              next_sda_oe = 1'b1; // [R6]
              next_state = idc_pkg::T_ACK;
              if (bytes == idc_pkg::BYTES_ADDR) begin
                next_word = {shreg, word[7:0]}; // [R9]
              end else begin
                next_word = {word[15:8], shreg};
                // only the full word reaches the converter [R10] [R18]
                next_code = word_code({word[15:8], shreg});
                next_soft_pd = shreg_pd(word[15:8]);
              end
            end
          end
        end
        idc_pkg::T_ACK: begin
          if (fall) begin
            // held low through the ninth pulse, released after it [R4] [R5]
            next_sda_oe = 1'b0;
            if (rw) begin
              next_tx = word[15:8]; // [R14]
              next_sda_oe = !word[15];
              next_state = idc_pkg::T_RD;
            end else if (bytes == idc_pkg::BYTES_ALL) begin
              next_state = idc_pkg::T_IGNORE; // [R7]
            end else begin
              next_state = idc_pkg::T_WR;
            end
          end
        end
        idc_pkg::T_RD: begin
          if (rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (fall) begin
            if (bitcnt == idc_pkg::BYTE_BITS) begin
              next_sda_oe = 1'b0;
              next_bitcnt = '0;
              next_state = idc_pkg::T_RACK;
            end else begin
              next_tx = {tx[6:0], 1'b0}; // [R14] [R5]
              next_sda_oe = !tx[6];
            end
          end
        end
        idc_pkg::T_RACK: begin
          if (fall) begin
            if (bytes == idc_pkg::BYTES_ADDR) begin
              next_bytes = idc_pkg::BYTES_HI;
              next_tx = word[7:0]; // [R14]
              next_sda_oe = !word[7];
              next_state = idc_pkg::T_RD;
            end else begin
              next_word = idc_pkg::WORD_RESET; // [R15]
              next_state = idc_pkg::T_IGNORE;
            end
          end
        end
        default: begin
          next_sda_oe = 1'b0; // idle and ignore stay off the line [R17]
        end
      endcase
    end
  end

  function automatic logic [9:0] word_code(input logic [15:0] w);
    word_code = w[idc_pkg::CODE_MSB:idc_pkg::CODE_LSB]; // [R12] [R13]
  endfunction : word_code

  function automatic logic shreg_pd(input logic [7:0] hi);
    shreg_pd = hi[idc_pkg::PD_BIT - int'(idc_pkg::BYTE_BITS)]; // [R11]
  endfunction : shreg_pd

  // registers of the engine
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= idc_pkg::T_IDLE;
      shreg <= '0;
      tx <= '0;
      bitcnt <= '0;
      bytes <= '0;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      word <= idc_pkg::WORD_RESET;
      code <= idc_pkg::CODE_RESET;
      soft_pd <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      tx <= next_tx;
      bitcnt <= next_bitcnt;
      bytes <= next_bytes;
      rw <= next_rw;
      sda_oe <= next_sda_oe;
      word <= next_word;
      code <= next_code;
      soft_pd <= next_soft_pd;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pin sets power-down with no clock; software bit follows on clock
  always_ff @(posedge CLK or negedge POWER_DOWN_REQUEST_N) begin
    if (!POWER_DOWN_REQUEST_N) begin
      POWER_DOWN <= 1'b1; // [R16]
    end else if (RESET) begin
      POWER_DOWN <= 1'b0;
    end else begin
      POWER_DOWN <= next_soft_pd; // [R11]
    end
  end

  assign CODE = code;
  assign INPUT_WORD = word;
  assign BUS.sda_t_o = 1'b0;
  assign BUS.sda_t_oe = sda_oe;
endmodule : idc_target

`default_nettype wire
